// [serial_pkg.sv]
// Shared constants and types for the host and auxiliary serial ports
package serial_pkg;

	// ----------------------------------------------------------------
	// Clock and baud generation
	// ----------------------------------------------------------------
	localparam longint CLK_HZ      = 25000000;
	localparam int     OVS         = 16;
	localparam int     ACC_W       = 16;
	localparam longint BAUD_MIN    = 115200;
	localparam longint BAUD_MAX    = 1500000;
	localparam longint BAUD_RESET  = 115200;
	localparam logic [3:0] MID_TICK  = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam logic [3:0] STOP_BIT  = 4'h9;

	// Phase increment of a 16x tick accumulator for a given baud
	function automatic logic [ACC_W-1:0] baud_inc(input longint baud);
		return ACC_W'((baud * OVS * (64'h1 << ACC_W)) / CLK_HZ);
	endfunction

	localparam logic [ACC_W-1:0] INC_MIN   = baud_inc(BAUD_MIN);
	localparam logic [ACC_W-1:0] INC_MAX   = baud_inc(BAUD_MAX);
	localparam logic [ACC_W-1:0] INC_RESET = baud_inc(BAUD_RESET);

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	localparam int HOST_DEPTH   = 1040;
	localparam int AUX_DEPTH    = 256;
	localparam int SHARED_BYTES = 1024;
	localparam int RTS_MARGIN   = 16;

	// ----------------------------------------------------------------
	// Packet framing and vendor commands
	// ----------------------------------------------------------------
	localparam logic [7:0]  PKT_CMD     = 8'h01;
	localparam logic [7:0]  PKT_ACL     = 8'h02;
	localparam logic [7:0]  PKT_SCO     = 8'h03;
	localparam logic [15:0] OP_SET_BAUD = 16'hFC01;
	localparam logic [15:0] OP_WAKE_EN  = 16'hFC02;

	typedef struct packed {
		logic [ACC_W-1:0] baudInc;
		logic             enable;
	} port_cfg_s;

	typedef struct packed {
		logic txd;
		logic rtsN;
	} link_out_s;

endpackage

// [hci_uart_with_host_wake.sv]
// Host serial port with host wake, auxiliary port, and their FIFOs
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------------
module serial_fifo import serial_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire logic                     clear,
	// Fill side
	input  wire logic [WIDTH-1:0]         inData,
	input  wire logic                     inValid,
	output logic                          inReady,
	// Drain side
	output logic [WIDTH-1:0]              outData,
	output logic                          outValid,
	input  wire logic                     outReady,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0]    count
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0]           mem [DEPTH];
	logic [AW-1:0]              wrPtr_q;
	logic [AW-1:0]              rdPtr_q;
	logic [$clog2(DEPTH+1)-1:0] count_q;
	wire                        push = inValid & inReady;
	wire                        pop  = outValid & outReady;

	assign inReady  = (count_q != ($clog2(DEPTH+1))'(DEPTH)) & ~clear;
	assign outValid = (count_q != '0) & ~clear;
	assign outData  = mem[rdPtr_q];
	assign count    = count_q;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (clear) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
			if (pop)  rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
			count_q <= count_q + (($clog2(DEPTH+1))'(push)) - (($clog2(DEPTH+1))'(pop));
		end
	end
endmodule

// ------------------------------------------------------------------------
// One serial port: baud ticks, receiver, transmitter, two FIFOs
// ------------------------------------------------------------------------
module serial_port_core import serial_pkg::*; #(
	parameter int DEPTH  = HOST_DEPTH,
	parameter int MARGIN = RTS_MARGIN
) (
	// Clock, reset and configuration
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire port_cfg_s    cfg,
	// Link
	input  wire logic         rxd,
	input  wire logic         ctsN,
	output link_out_s         link,
	// Bytes to send
	input  wire logic [7:0]   inData,
	input  wire logic         inValid,
	output logic              inReady,
	// Bytes received
	output logic [7:0]        outData,
	output logic              outValid,
	input  wire logic         outReady,
	// Snoop of received bytes and transmit activity
	output logic [7:0]        rxByte,
	output logic              rxStrobe,
	output logic              txPending
);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] RTS_LEVEL = CW'(DEPTH - MARGIN);

	logic [ACC_W-1:0] acc_q;
	logic             tick;
	logic             rxBusy_q, txBusy_q, rtsN_q;
	logic [3:0]       rxTick_q, rxBit_q, txTick_q, txBit_q;
	logic [7:0]       rxShift_q, rxByte_q;
	logic             rxStrobe_q;
	logic [9:0]       txShift_q;
	logic [7:0]       txData;
	logic             txValid;
	logic [CW-1:0]    rxCount;
	wire              flush   = ~cfg.enable;
	wire              txStart = ~txBusy_q & txValid & ~ctsN & cfg.enable;
	wire              rxSample = rxBusy_q & tick & (rxTick_q == MID_TICK);

	// Fractional accumulator allows any rate, not only integer divisors
	assign tick = ({1'b0, acc_q} + {1'b0, cfg.baudInc}) > {1'b1, {ACC_W{1'b0}}} - 1'b1;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) acc_q <= '0;
		else          acc_q <= acc_q + cfg.baudInc;
	end

	// ----------------------------------------------------------------
	// Receiver, 16x oversampled, sampled mid-bit for rate tolerance
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rxBusy_q   <= 1'b0;
			rxTick_q   <= '0;
			rxBit_q    <= '0;
			rxShift_q  <= '0;
			rxByte_q   <= '0;
			rxStrobe_q <= 1'b0;
		end else begin
			rxStrobe_q <= 1'b0;
			if (!rxBusy_q && tick && !rxd) begin
				rxBusy_q <= 1'b1;
				rxTick_q <= '0;
				rxBit_q  <= '0;
			end else if (rxBusy_q && tick) begin
				rxTick_q <= rxTick_q + 1'b1;
			end
			if (rxSample) begin
				rxBit_q <= rxBit_q + 1'b1;
				if (rxBit_q == '0 && rxd) begin
					rxBusy_q <= 1'b0;
				end else if (rxBit_q == STOP_BIT) begin
					rxBusy_q   <= 1'b0;
					rxStrobe_q <= rxd;
					rxByte_q   <= rxShift_q;
				end else if (rxBit_q != '0) begin
					rxShift_q <= {rxd, rxShift_q[7:1]};
				end
			end
		end
	end

	assign rxByte   = rxByte_q;
	assign rxStrobe = rxStrobe_q;

	// Overrun drops the byte; the RTS margin should prevent it
	serial_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
		.clock    (clock),
		.reset_n  (reset_n),
		.clear    (flush),
		.inData   (rxByte_q),
		.inValid  (rxStrobe_q),
		.inReady  (),
		.outData  (outData),
		.outValid (outValid),
		.outReady (outReady),
		.count    (rxCount)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) rtsN_q <= 1'b1;
		else          rtsN_q <= flush | (rxCount >= RTS_LEVEL);
	end

	// ----------------------------------------------------------------
	// Transmitter; CTS is checked only between characters
	// ----------------------------------------------------------------
	serial_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
		.clock    (clock),
		.reset_n  (reset_n),
		.clear    (flush),
		.inData   (inData),
		.inValid  (inValid),
		.inReady  (inReady),
		.outData  (txData),
		.outValid (txValid),
		.outReady (txStart),
		.count    ()
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			txBusy_q  <= 1'b0;
			txTick_q  <= '0;
			txBit_q   <= '0;
			txShift_q <= 10'h3FF;
		end else if (txStart) begin
			txBusy_q  <= 1'b1;
			txTick_q  <= '0;
			txBit_q   <= '0;
			txShift_q <= {1'b1, txData, 1'b0};
		end else if (txBusy_q && tick) begin
			txTick_q <= txTick_q + 1'b1;
			if (txTick_q == LAST_TICK) begin
				txShift_q <= {1'b1, txShift_q[9:1]};
				txBit_q   <= txBit_q + 1'b1;
				if (txBit_q == STOP_BIT) txBusy_q <= 1'b0;
			end
		end
	end

	assign link.txd  = txShift_q[0];
	assign link.rtsN = rtsN_q;
	assign txPending = txBusy_q | txValid;
endmodule

// ------------------------------------------------------------------------
// Top: host port with command snoop and wake, auxiliary port with pin mux
// ------------------------------------------------------------------------
module hci_uart_with_host_wake import serial_pkg::*; #(
	parameter int GPIO_N     = 16,
	parameter int HOST_BYTES = HOST_DEPTH,
	parameter int AUX_BYTES  = AUX_DEPTH
) (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// Host link
	input  wire logic                      hostRxd,
	input  wire logic                      hostCtsN,
	output logic                           hostTxd,
	output logic                           hostRtsN,
	output logic                           hostWake,
	// Host bytes to send
	input  wire logic [7:0]                hostInData,
	input  wire logic                      hostInValid,
	output logic                           hostInReady,
	// Host bytes received
	output logic [7:0]                     hostOutData,
	output logic                           hostOutValid,
	input  wire logic                      hostOutReady,
	// Buffer sharing with serial unit one
	input  wire logic                      unitOneOwnsBuffer,
	// Auxiliary port setup
	input  wire logic [ACC_W-1:0]          auxBaudInc,
	input  wire logic [$clog2(GPIO_N)-1:0] auxRxSel,
	input  wire logic [$clog2(GPIO_N)-1:0] auxTxSel,
	input  wire logic [$clog2(GPIO_N)-1:0] auxCtsSel,
	input  wire logic [$clog2(GPIO_N)-1:0] auxRtsSel,
	// General-purpose pins
	input  wire logic [GPIO_N-1:0]         gpioIn,
	output logic [GPIO_N-1:0]              gpioOut,
	output logic [GPIO_N-1:0]              gpioOe,
	// Auxiliary bytes to send
	input  wire logic [7:0]                auxInData,
	input  wire logic                      auxInValid,
	output logic                           auxInReady,
	// Auxiliary bytes received
	output logic [7:0]                     auxOutData,
	output logic                           auxOutValid,
	input  wire logic                      auxOutReady
);
	localparam int SW = $clog2(GPIO_N);

	typedef enum logic [4:0] {
		D_TYPE  = 5'h01,
		D_HEAD  = 5'h02,
		D_LENLO = 5'h04,
		D_LENHI = 5'h08,
		D_BODY  = 5'h10
	} dec_e;

	function automatic logic [ACC_W-1:0] clamp_inc(input logic [ACC_W-1:0] inc);
		return (inc < INC_MIN) ? INC_MIN : (inc > INC_MAX) ? INC_MAX : inc;
	endfunction

	function automatic logic pin_pick(input logic [GPIO_N-1:0] pins,
	                                  input logic [SW-1:0] sel);
		return pins[sel];
	endfunction

	dec_e             st_q;
	logic             isCmd_q, isAcl_q, hdrCnt_q, wakeEn_q, hostWake_q;
	logic [15:0]      opcode_q, len_q, idx_q, param_q, paramNext;
	logic [ACC_W-1:0] hostInc_q;
	logic [7:0]       rxByte;
	logic             rxStrobe, hostTxPending;
	logic             apply;
	logic [15:0]      applyParam;
	link_out_s        hostLink, auxLink;
	port_cfg_s        hostCfg, auxCfg;
	logic [GPIO_N-1:0] gpioOut_q, gpioOe_q, gpioOut_d, gpioOe_d;

	// ----------------------------------------------------------------
	// Host port; storage unavailable while serial unit one owns it
	// ----------------------------------------------------------------
	assign hostCfg.baudInc = hostInc_q;
	assign hostCfg.enable  = ~unitOneOwnsBuffer;

	// Flow control: tied-low CTS from a two-wire host keeps sending
	serial_port_core #(.DEPTH(HOST_BYTES), .MARGIN(RTS_MARGIN)) hostPort (
		.clock     (clock),
		.reset_n   (reset_n),
		.cfg       (hostCfg),
		.rxd       (hostRxd),
		.ctsN      (hostCtsN),
		.link      (hostLink),
		.inData    (hostInData),
		.inValid   (hostInValid),
		.inReady   (hostInReady),
		.outData   (hostOutData),
		.outValid  (hostOutValid),
		.outReady  (hostOutReady),
		.rxByte    (rxByte),
		.rxStrobe  (rxStrobe),
		.txPending (hostTxPending)
	);

	assign hostTxd  = hostLink.txd;
	assign hostRtsN = hostLink.rtsN;

	// ----------------------------------------------------------------
	// Packet snoop for vendor commands; bytes still reach the FIFO
	// ----------------------------------------------------------------
	assign paramNext = (idx_q == 16'h0000) ? {8'h00, rxByte} :
	                   (idx_q == 16'h0001) ? {rxByte, param_q[7:0]} : param_q;
	wire   lenZero   = (st_q == D_LENLO) && !isAcl_q && (rxByte == 8'h00);
	wire   bodyEnd   = (st_q == D_BODY) && (idx_q == len_q - 16'h0001);
	assign apply      = rxStrobe & isCmd_q & (lenZero | bodyEnd);
	assign applyParam = lenZero ? 16'h0000 : paramNext;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q     <= D_TYPE;
			isCmd_q  <= 1'b0;
			isAcl_q  <= 1'b0;
			hdrCnt_q <= 1'b0;
			opcode_q <= '0;
			len_q    <= '0;
			idx_q    <= '0;
			param_q  <= '0;
		end else if (rxStrobe) begin
			case (st_q)
				D_TYPE: begin
					isCmd_q  <= (rxByte == PKT_CMD);
					isAcl_q  <= (rxByte == PKT_ACL);
					hdrCnt_q <= 1'b0;
					if (rxByte == PKT_CMD || rxByte == PKT_ACL || rxByte == PKT_SCO) begin
						st_q <= D_HEAD;
					end
				end
				D_HEAD: begin
					opcode_q <= {rxByte, opcode_q[15:8]};
					hdrCnt_q <= ~hdrCnt_q;
					if (hdrCnt_q) st_q <= D_LENLO;
				end
				D_LENLO: begin
					len_q <= {8'h00, rxByte};
					idx_q <= '0;
					if (isAcl_q)             st_q <= D_LENHI;
					else if (rxByte == 8'h00) st_q <= D_TYPE;
					else                      st_q <= D_BODY;
				end
				D_LENHI: begin
					len_q <= {rxByte, len_q[7:0]};
					st_q  <= ({rxByte, len_q[7:0]} == 16'h0000) ? D_TYPE : D_BODY;
				end
				D_BODY: begin
					param_q <= paramNext;
					idx_q   <= idx_q + 16'h0001;
					if (bodyEnd) st_q <= D_TYPE;
				end
				default: st_q <= D_TYPE;
			endcase
		end
	end

	// Rate switches at once; host should wait for the reply first
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hostInc_q <= INC_RESET;
			wakeEn_q  <= 1'b0;
		end else if (apply) begin
			if (opcode_q == OP_SET_BAUD) hostInc_q <= clamp_inc(applyParam);
			if (opcode_q == OP_WAKE_EN)  wakeEn_q  <= applyParam[0];
		end
	end

	// Wake only when something waits to go out to the host
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) hostWake_q <= 1'b0;
		else          hostWake_q <= wakeEn_q & hostTxPending;
	end

	assign hostWake = hostWake_q;

	// ----------------------------------------------------------------
	// Auxiliary port on freely routed pins
	// ----------------------------------------------------------------
	assign auxCfg.baudInc = clamp_inc(auxBaudInc);
	assign auxCfg.enable  = 1'b1;

	serial_port_core #(.DEPTH(AUX_BYTES), .MARGIN(RTS_MARGIN)) auxPort (
		.clock     (clock),
		.reset_n   (reset_n),
		.cfg       (auxCfg),
		.rxd       (pin_pick(gpioIn, auxRxSel)),
		.ctsN      (pin_pick(gpioIn, auxCtsSel)),
		.link      (auxLink),
		.inData    (auxInData),
		.inValid   (auxInValid),
		.inReady   (auxInReady),
		.outData   (auxOutData),
		.outValid  (auxOutValid),
		.outReady  (auxOutReady),
		.rxByte    (),
		.rxStrobe  (),
		.txPending ()
	);

	// Transmit wins if both outputs land on one pin
	for (genvar i = 0; i < GPIO_N; i++) begin : gPin
		wire isTx  = (auxTxSel == SW'(i));
		wire isRts = (auxRtsSel == SW'(i));
		assign gpioOut_d[i] = isTx ? auxLink.txd : isRts ? auxLink.rtsN : 1'b1;
		assign gpioOe_d[i]  = isTx | isRts;
	end

	// One register process for all pins keeps each vector single-driven
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gpioOut_q <= '1;
			gpioOe_q  <= '0;
		end else begin
			gpioOut_q <= gpioOut_d;
			gpioOe_q  <= gpioOe_d;
		end
	end

	assign gpioOut = gpioOut_q;
	assign gpioOe  = gpioOe_q;
endmodule

// [hci_uart_with_host_wake_asserts.sv]
// Pin-level checks of the host serial port
`timescale 1ns/1ps
module hci_uart_with_host_wake_asserts import serial_pkg::*; (
	// Clock and reset
	input wire logic       clock,
	input wire logic       reset_n,
	// Host link
	input wire logic       hostCtsN,
	input wire logic       hostTxd,
	input wire logic       hostRtsN,
	input wire logic       hostWake,
	// Streams and sharing
	input wire logic       hostInReady,
	input wire logic [7:0] hostOutData,
	input wire logic       hostOutValid,
	input wire logic       hostOutReady,
	input wire logic       unitOneOwnsBuffer
);
	// --------------------------------
	// Helpers
	// --------------------------------
	logic [11:0] ctsHigh_q;
	logic [23:0] popHist_q;
	logic        wakeSeen_q;
	wire         pop       = hostOutValid & hostOutReady;
	wire  [23:0] popHist_d = {popHist_q[15:0], hostOutData};

	// Wake-enable seen only once its last byte is popped, so host must not stall
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctsHigh_q  <= 12'h000;
			popHist_q  <= 24'h000000;
			wakeSeen_q <= 1'b0;
		end else begin
			ctsHigh_q <= hostCtsN ? ctsHigh_q + {11'h000, ~&ctsHigh_q} : 12'h000;
			if (pop) begin
				popHist_q  <= popHist_d;
				wakeSeen_q <= wakeSeen_q | (popHist_d == 24'hFC0101);
			end
		end
	end

	// --------------------------------
	// Properties
	// --------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_rts_share;
		unitOneOwnsBuffer ##1 unitOneOwnsBuffer |-> hostRtsN;
	endproperty
	a_rts_share: assert property (p_rts_share) else $error("rts low while lent");

	property p_share_intake;
		unitOneOwnsBuffer |-> !hostInReady && !hostOutValid;
	endproperty
	a_share_intake: assert property (p_share_intake) else $error("stream open while lent");

	property p_rts_release;
		$rose(reset_n) && !unitOneOwnsBuffer |-> ##[1:2] !hostRtsN;
	endproperty
	a_rts_release: assert property (p_rts_release) else $error("rts stuck after reset");

	// Bound exceeds one whole character at the slowest rate
	property p_cts_hold;
		ctsHigh_q > 12'h898 |-> hostTxd;
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("sent while cts high");

	property p_low_width;
		$fell(hostTxd) |-> (!hostTxd)[*8];
	endproperty
	a_low_width: assert property (p_low_width) else $error("short low bit");

	property p_high_width;
		$rose(hostTxd) |-> hostTxd[*8];
	endproperty
	a_high_width: assert property (p_high_width) else $error("short high bit");

	property p_wake_gate;
		hostWake |-> wakeSeen_q;
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake before enable");

	property p_wake_tx;
		wakeSeen_q && $fell(hostTxd) |-> ##1 hostWake;
	endproperty
	a_wake_tx: assert property (p_wake_tx) else $error("no wake while sending");
endmodule

bind hci_uart_with_host_wake hci_uart_with_host_wake_asserts i_checks (
	.clock            (clock),
	.reset_n          (reset_n),
	.hostCtsN         (hostCtsN),
	.hostTxd          (hostTxd),
	.hostRtsN         (hostRtsN),
	.hostWake         (hostWake),
	.hostInReady      (hostInReady),
	.hostOutData      (hostOutData),
	.hostOutValid     (hostOutValid),
	.hostOutReady     (hostOutReady),
	.unitOneOwnsBuffer(unitOneOwnsBuffer)
);

// [host_serial_model.sv]
// Behavioural host processor on the far side of the host serial port
`timescale 1ns/1ps
module host_serial_model (
	// Clock
	input  wire logic clock,
	// Link; device RTS left unused by this host
	output logic      txLine,
	input  wire logic rxLine
);
	// Idle line is high
	initial txLine = 1'b1;

	// Start, eight bits LSB first, stop, one idle bit
	// Bit time in whole clocks keeps host error well inside five percent
	task automatic sendByte(input logic [7:0] data, input int bitClk, input logic stopLvl);
		@(negedge clock);
		txLine = 1'b0;
		repeat (bitClk) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			txLine = data[i];
			repeat (bitClk) @(negedge clock);
		end
		txLine = stopLvl;
		repeat (bitClk) @(negedge clock);
		txLine = 1'b1;
		repeat (bitClk) @(negedge clock);
	endtask

	// Samples mid-bit; ok low on timeout, bad start or bad stop
	task automatic recvByte(input int bitClk, output logic [7:0] data, output logic ok);
		int n;
		n = 0;
		data = 8'h00;
		while (rxLine !== 1'b0 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		repeat (bitClk / 2) @(negedge clock);
		ok = (n < 20000) && (rxLine === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (bitClk) @(negedge clock);
			data[i] = rxLine;
		end
		repeat (bitClk) @(negedge clock);
		ok = ok && (rxLine === 1'b1);
	endtask
endmodule

// [hci_uart_with_host_wake_test.sv]
// Self-checking bench of the host and auxiliary serial ports
`timescale 1ns/1ps
module hci_uart_with_host_wake_test import serial_pkg::*;;
	// --------------------------------
	// Signals
	// --------------------------------
	localparam int CYCLE_LIMIT = 60000;
	logic        clock;
	logic        reset_n;
	logic        hostCtsN;
	logic        hostInValid;
	logic        hostOutReady;
	logic        unitOneOwnsBuffer;
	logic        auxInValid;
	logic        auxOutReady;
	logic [7:0]  hostInData;
	logic [7:0]  auxInData;
	logic [15:0] auxBaudInc;
	logic [15:0] pads;
	logic [3:0]  auxSel [4];
	wire         hostRxd;
	wire         hostTxd;
	wire         hostRtsN;
	wire         hostWake;
	wire         hostInReady;
	wire         hostOutValid;
	wire         auxInReady;
	wire         auxOutValid;
	wire  [7:0]  hostOutData;
	wire  [7:0]  auxOutData;
	wire  [15:0] gpioOut;
	wire  [15:0] gpioOe;
	wire  [15:0] gpioIn = (gpioOut & gpioOe) | (pads & ~gpioOe);
	logic [7:0]  rxQ [$];
	int          bitClk = 217;
	int          cycles = 0;
	int          err_count = 0;
	int          compares = 0;

	hci_uart_with_host_wake i_dut (
		.clock(clock), .reset_n(reset_n), .hostRxd(hostRxd), .hostCtsN(hostCtsN),
		.hostTxd(hostTxd), .hostRtsN(hostRtsN), .hostWake(hostWake),
		.hostInData(hostInData), .hostInValid(hostInValid), .hostInReady(hostInReady),
		.hostOutData(hostOutData), .hostOutValid(hostOutValid),
		.hostOutReady(hostOutReady), .unitOneOwnsBuffer(unitOneOwnsBuffer),
		.auxBaudInc(auxBaudInc), .auxRxSel(auxSel[0]), .auxTxSel(auxSel[1]),
		.auxCtsSel(auxSel[2]), .auxRtsSel(auxSel[3]), .gpioIn(gpioIn),
		.gpioOut(gpioOut), .gpioOe(gpioOe), .auxInData(auxInData),
		.auxInValid(auxInValid), .auxInReady(auxInReady), .auxOutData(auxOutData),
		.auxOutValid(auxOutValid), .auxOutReady(auxOutReady)
	);
	host_serial_model i_host (.clock(clock), .txLine(hostRxd), .rxLine(hostTxd));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// --------------------------------
	// Monitors and helpers
	// --------------------------------
	always @(posedge clock) begin
		if (hostOutValid === 1'b1 && hostOutReady === 1'b1) rxQ.push_back(hostOutData);
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			err_count++;
			$display("CHECK FAILED at %0t: run too long", $time);
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic pushHost(input logic [7:0] data);
		int n;
		n = 0;
		@(negedge clock);
		hostInData = data;
		hostInValid = 1'b1;
		while (hostInReady !== 1'b1 && n < 2000) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		hostInValid = 1'b0;
	endtask

	// Host packets: type, opcode low, opcode high, length, parameters
	task automatic sendCmd(input logic [47:0] bytes, input int n);
		for (int i = 0; i < n; i++) i_host.sendByte(bytes[47-8*i -: 8], bitClk, 1'b1);
	endtask

	task automatic xchg(input logic [7:0] toDev, input logic [7:0] toHost);
		logic [7:0] got;
		logic       ok;
		rxQ.delete();
		fork
			i_host.sendByte(toDev, bitClk, 1'b1);
			i_host.recvByte(bitClk, got, ok);
			pushHost(toHost);
		join
		repeat (4) @(negedge clock);
		check(16'(rxQ.size()), 16'h0001, "rx count");
		check({8'h00, rxQ[0]}, {8'h00, toDev}, "rx byte");
		check({7'h00, ok, got}, {8'h01, toHost}, "tx byte");
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic tReset();
		repeat (5) @(negedge clock);
		check({13'h0, hostTxd, hostRtsN, hostWake}, 16'h0006, "reset pins");
		check(gpioOe, 16'h0000, "reset oe");
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		repeat (3) @(negedge clock);
		check(16'(hostRtsN), 16'h0000, "rts up");
		xchg(8'h1E, 8'hD4);
		rxQ.delete();
		i_host.sendByte(8'h0F, bitClk, 1'b0);
		repeat (4) @(negedge clock);
		check(16'(rxQ.size()), 16'h0000, "bad stop kept");
		$display("reset test done");
	endtask

	task automatic tCts(input logic expWake);
		logic [7:0] got;
		logic       ok;
		@(negedge clock);
		hostCtsN = 1'b1;
		pushHost(8'h81);
		repeat (2400) @(negedge clock);
		check(16'(hostTxd), 16'h0001, "held txd");
		check(16'(hostWake), 16'(expWake), "wake");
		fork
			i_host.recvByte(bitClk, got, ok);
			begin
				@(negedge clock);
				hostCtsN = 1'b0;
			end
		join
		check({7'h00, ok, got}, 16'h0181, "held byte");
		$display("cts test done");
	endtask

	// Rates above the reset one, including one between common settings
	task automatic tBaud();
		longint     rates [3] = '{500000, 921600, 1500000};
		logic [15:0] inc;
		foreach (rates[k]) begin
			inc = 16'((rates[k] * 16 * 65536) / 25000000);
			sendCmd({8'h01, 8'h01, 8'hFC, 8'h02, inc[7:0], inc[15:8]}, 6);
			bitClk = int'((25000000 + rates[k] / 2) / rates[k]);
			xchg(8'h80, 8'h01);
		end
		$display("baud test done");
	endtask

	task automatic tFill();
		int n;
		n = 0;
		@(negedge clock);
		hostCtsN = 1'b1;
		hostInData = 8'h55;
		hostInValid = 1'b1;
		while (hostInReady === 1'b1 && n < 1100) begin
			@(negedge clock);
			n++;
		end
		hostInValid = 1'b0;
		check(16'(n), 16'h0410, "fill depth");
		unitOneOwnsBuffer = 1'b1;
		repeat (3) @(negedge clock);
		check({13'h0, hostRtsN, hostInReady, hostOutValid}, 16'h0004, "lent");
		unitOneOwnsBuffer = 1'b0;
		hostCtsN = 1'b0;
		repeat (300) @(negedge clock);
		check({12'h0, hostRtsN, hostInReady, hostTxd, hostWake}, 16'h0006, "flushed");
		$display("fill test done");
	endtask

	// Aux tx looped back to aux rx through pin 4; cts on pin 5 held low
	task automatic tAux();
		int n;
		n = 0;
		@(negedge clock);
		auxInData = 8'h96;
		auxInValid = 1'b1;
		check(16'(auxInReady), 16'h0001, "aux ready");
		@(negedge clock);
		auxInValid = 1'b0;
		while (auxOutValid !== 1'b1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		check({8'h00, auxOutData}, 16'h0096, "aux byte");
		check({13'h0, gpioOe[6:4]}, 16'h0005, "aux pins");
		check(16'(gpioOut[6]), 16'h0000, "aux rts");
		auxOutReady = 1'b1;
		@(negedge clock);
		check(16'(auxOutValid), 16'h0000, "aux pop");
		$display("aux test done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		reset_n = 1'b0;
		hostCtsN = 1'b0;
		hostInValid = 1'b0;
		hostInData = 8'h00;
		hostOutReady = 1'b1;
		unitOneOwnsBuffer = 1'b0;
		auxInValid = 1'b0;
		auxInData = 8'h00;
		auxOutReady = 1'b0;
		auxBaudInc = 16'hF5C2;
		pads = 16'hFFDF;
		auxSel = '{4'h4, 4'h4, 4'h5, 4'h6};
		tReset();
		tCts(1'b0);
		tBaud();
		// Data packet with a two-byte length must be skipped whole
		sendCmd({8'h02, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01}, 6);
		sendCmd({8'h01, 8'h02, 8'hFC, 8'h01, 8'h01, 8'h00}, 5);
		tCts(1'b1);
		tFill();
		tAux();
		conclude();
	end
endmodule
